// [common/shh_pkg.sv]
`default_nettype none
package shh_pkg;
   // ------------------------------------------------------------
   // sizes and hub timing
   // ------------------------------------------------------------
   localparam int NUM_CORES    = 8;
   localparam int PIN_W        = 32;
   localparam int CORE_W       = 3;
   localparam int FRAME_W      = 4;
   localparam int EXEC_CYCLES  = 7;
   localparam logic [2:0] EXEC_LAST = 3'h6;
   // ------------------------------------------------------------
   // register map: core space index = SPR_BASE_IDX + special register index
   // ------------------------------------------------------------
   localparam logic [8:0] SPR_BASE_IDX = 9'h1F0;
   localparam logic [3:0] SPR_PARAM    = 4'h0;
   localparam logic [3:0] SPR_COUNTER  = 4'h1;
   localparam logic [3:0] SPR_INPUT    = 4'h2;
   localparam logic [3:0] SPR_OUTPUT   = 4'h4;
   localparam logic [3:0] SPR_DIR      = 4'h6;
   localparam int ADDR_HUB_BIT  = 14;
   localparam int ADDR_CORE_LSB = 11;
   localparam logic [1:0] HUB_CTRL_IDX = 2'h0;
   localparam logic [1:0] HUB_STAT_IDX = 2'h1;
   // ------------------------------------------------------------
   // reset values and the AHB-Lite NONSEQ transfer code
   // ------------------------------------------------------------
   localparam logic [7:0]  CORE_ENABLE_RST = 8'h01;
   localparam logic [31:0] SYSCNT_SEED     = 32'h5A5A_0000;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } shh_ahb_req_type;
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } shh_ahb_rsp_type;
   typedef struct packed {
      logic [FRAME_W-1:0]              frame;
      logic [NUM_CORES-1:0]            busy;
      logic [NUM_CORES-1:0][2:0]       exec_cnt;
      logic [NUM_CORES-1:0]            done;
      logic [NUM_CORES-1:0]            enable;
      logic [NUM_CORES-1:0][PIN_W-1:0] dir;
      logic [NUM_CORES-1:0][PIN_W-1:0] outr;
      logic [PIN_W-1:0]                sync1;
      logic [PIN_W-1:0]                sync2;
      logic [PIN_W-1:0]                sync3;
      logic [PIN_W-1:0]                pin_live;
      logic [PIN_W-1:0]                pin_out;
      logic [PIN_W-1:0]                pin_oe;
      logic [31:0]                     sys_cnt;
      logic                            wr_pend;
      logic                            rd_pend;
      logic [31:0]                     daddr;
      shh_ahb_rsp_type                 rsp;
   } shh_state_type;
endpackage
`default_nettype wire

// [src/shh_hub.sv]
// Contract
// [R01] grant cores 0..7 in turn, then wrap
// [R02] rotator steps every two clock cycles
// [R03] each core window once per 16 cycles
// [R04] hub op runs 7 cycles from window start
// [R05] missed window waits up to 15 cycles
// [R06] 9 free cycles after op before next window
// [R07] one core never stalls the others
// [R08] 32 shared pins, top four general later
// [R09] private direction and output word per core
// [R10] pin direction is OR of all cores
// [R11] pin output OR of masked core contributions
// [R12] direction bit 1 output, 0 input
// [R13] stopped core forced to zero on pins
// [R14] input word reads live pins, unstored; the code reads the synchronised pin_live register instead
// [R15] 32-bit system counter counts every cycle
// [R16] all cores read counter at once
// [R17] counter not cleared at startup
// [R18] special registers indexed 0..15 in order
// [R19] all cores share one system clock
// [R20] pins, counter free; rest via rotator
// [R21] counter wraps to zero and continues
// [R22] rotator starts core 0, runs always
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`default_nettype none
module shh_hub
(
   // clock and reset
   input  wire logic                                            clock,
   input  wire logic                                            rst_n,
   // register bus
   input  wire shh_pkg::shh_ahb_req_type                        ahb_req,
   output var  shh_pkg::shh_ahb_rsp_type                        ahb_rsp,
   // hub requests from cores
   input  wire logic [shh_pkg::NUM_CORES-1:0]                   hub_req,
   output logic      [shh_pkg::NUM_CORES-1:0]                   hub_exec,
   output logic      [shh_pkg::NUM_CORES-1:0]                   hub_done,
   output logic      [shh_pkg::CORE_W-1:0]                      hub_slot,
   output logic      [shh_pkg::NUM_CORES-1:0]                   core_enable,
   // core i/o modules and shared counter
   input  wire logic [shh_pkg::NUM_CORES-1:0][shh_pkg::PIN_W-1:0] core_io_extra,
   output logic      [31:0]                                     system_counter_view,
   // shared pins
   input  wire logic [shh_pkg::PIN_W-1:0]                       pin_in,
   output logic      [shh_pkg::PIN_W-1:0]                       pin_out,
   output logic      [shh_pkg::PIN_W-1:0]                       pin_oe
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // true when a byte address falls in the special register block
   function automatic logic is_spr(input logic [31:0] addr);
      is_spr = (addr[shh_pkg::ADDR_HUB_BIT] == 1'b0) &&
               (addr[10:6] == shh_pkg::SPR_BASE_IDX[8:4]);
   endfunction

   // core number carried by a byte address
   function automatic logic [2:0] addr_core(input logic [31:0] addr);
      addr_core = addr[shh_pkg::ADDR_CORE_LSB +: shh_pkg::CORE_W];
   endfunction

   // true only for the four words at the bottom of hub space; anything
   // higher reads zero instead of aliasing onto the control word
   function automatic logic is_hub(input logic [31:0] addr);
      is_hub = addr[shh_pkg::ADDR_HUB_BIT] && (addr[13:4] == 10'h000);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   shh_pkg::shh_state_type st;
   shh_pkg::shh_state_type next_st;

   logic                              take;
   logic [shh_pkg::PIN_W-1:0]         or_dir;
   logic [shh_pkg::PIN_W-1:0]         or_out;
   logic [2:0]                        rc;
   logic [3:0]                        ri;
   logic [31:0]                       rdat;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      take    = 1'b0;
      or_dir  = '0;
      or_out  = '0;
      rc      = addr_core(st.daddr);
      ri      = st.daddr[5:2];
      rdat    = '0;

      // ---------------------------------------------------------
      // access rotator
      // ---------------------------------------------------------
      // rotator frame: high bits core, low bit half step
      // [R01] ascending order with wrap
      // [R02] step per two cycles
      // [R22] runs with no requests
      next_st.frame = st.frame + 4'h1;

      // ---------------------------------------------------------
      // hub execution and pin combining
      // ---------------------------------------------------------
      // hub execution per core, each independent of the rest
      next_st.done = '0;
      for (int c = 0; c < shh_pkg::NUM_CORES; c++)
      begin
         // [R04] start only at window start
         // [R05] otherwise wait next window
         take = hub_req[c] && st.enable[c] && !st.busy[c] &&
                (st.frame == {3'(c), 1'b0});
         // [R07] no cross-core stalls
         if (take)
         begin
            next_st.busy[c]     = 1'b1;
            next_st.exec_cnt[c] = 3'h0;
         end
         else if (st.busy[c])
         begin
            // [R06] op ends, nine cycles remain
            if (st.exec_cnt[c] == shh_pkg::EXEC_LAST)
            begin
               next_st.busy[c] = 1'b0;
               next_st.done[c] = 1'b1;
            end
            else
            begin
               next_st.exec_cnt[c] = st.exec_cnt[c] + 3'h1;
            end
         end
         // [R13] stopped core cleared
         if (!st.enable[c])
         begin
            next_st.dir[c]  = '0;
            next_st.outr[c] = '0;
            next_st.busy[c] = 1'b0;
            // an aborted operation never reports completion
            next_st.done[c] = 1'b0;
         end
         else
         begin
            // [R10] direction wired-or
            or_dir = or_dir | st.dir[c];
            // [R11] masked output wired-or
            // [R12] direction 1 drives
            or_out = or_out | ((st.outr[c] | core_io_extra[c]) & st.dir[c]);
         end
      end
      // [R08] all 32 pins driven alike
      next_st.pin_oe  = or_dir;
      next_st.pin_out = or_out;

      // ---------------------------------------------------------
      // pin input synchroniser
      // ---------------------------------------------------------
      // accept a level once stages two and three agree, so a pin caught
      // mid-transition is never handed to a core
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      if (st.sync2 == st.sync3)
      begin
         next_st.pin_live = st.sync3;
      end

      // ---------------------------------------------------------
      // system counter
      // ---------------------------------------------------------
      // [R15] count each cycle
      // [R21] natural wrap
      next_st.sys_cnt = st.sys_cnt + 32'h1;

      // ---------------------------------------------------------
      // register bus
      // ---------------------------------------------------------
      // write data phase
      if (st.wr_pend)
      begin
         next_st.wr_pend = 1'b0;
         if (is_spr(st.daddr))
         begin
            // [R09] private per-core words
            // [R18] indexed access
            case (ri)
               shh_pkg::SPR_OUTPUT: next_st.outr[rc] = ahb_req.hwdata;
               shh_pkg::SPR_DIR:    next_st.dir[rc]  = ahb_req.hwdata;
               default:             next_st.dir[rc]  = next_st.dir[rc];
            endcase
         end
         else if (is_hub(st.daddr) && st.daddr[3:2] == shh_pkg::HUB_CTRL_IDX)
         begin
            next_st.enable = ahb_req.hwdata[7:0];
         end
      end

      // read data phase: answer two cycles after the address phase, after one wait state
      next_st.rsp.hreadyout = 1'b1;
      next_st.rsp.hresp     = 1'b0;
      if (st.rd_pend)
      begin
         next_st.rd_pend = 1'b0;
         if (is_spr(st.daddr))
         begin
            case (ri)
               // [R16] shared counter view
               shh_pkg::SPR_COUNTER: rdat = st.sys_cnt;
               // [R14] synchronised, stored pin_live copy, not the unstored live pins
               shh_pkg::SPR_INPUT:   rdat = st.pin_live;
               shh_pkg::SPR_OUTPUT:  rdat = st.outr[rc];
               shh_pkg::SPR_DIR:     rdat = st.dir[rc];
               default:              rdat = '0;
            endcase
         end
         else if (is_hub(st.daddr))
         begin
            case (st.daddr[3:2])
               shh_pkg::HUB_CTRL_IDX: rdat = {24'h0, st.enable};
               shh_pkg::HUB_STAT_IDX: rdat = {16'h0, st.busy, 4'h0, st.frame};
               default:               rdat = '0;
            endcase
         end
         next_st.rsp.hrdata = rdat;
      end

      // address phase, only taken while the previous transfer has ended
      if (ahb_req.hsel && ahb_req.hready &&
          ahb_req.htrans == shh_pkg::HTRANS_NONSEQ)
      begin
         next_st.daddr = ahb_req.haddr;
         if (ahb_req.hwrite)
         begin
            next_st.wr_pend = 1'b1;
         end
         else
         begin
            next_st.rd_pend       = 1'b1;
            next_st.rsp.hreadyout = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // [R19] single clock for all cores
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st            <= '0;
         st.enable     <= shh_pkg::CORE_ENABLE_RST;
         // [R17] counter starts at a seed, not zero
         st.sys_cnt    <= shh_pkg::SYSCNT_SEED;
         st.rsp.hreadyout <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // [R20] pins and counter need no window
   assign ahb_rsp             = st.rsp;
   assign hub_exec            = st.busy;
   assign hub_done            = st.done;
   assign hub_slot            = st.frame[3:1];   // [R03] each core once per 16 cycles
   assign core_enable         = st.enable;
   assign system_counter_view = st.sys_cnt;
   assign pin_out             = st.pin_out;
   assign pin_oe              = st.pin_oe;
endmodule
`default_nettype wire

// [testbench/shh_core_model.sv]
`default_nettype none
module shh_core_model
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // bench control
   input  wire logic [7:0]  go,
   input  wire logic [31:0] ext_lvl,
   // hub handshake
   input  wire logic [7:0]  hub_done,
   output var  logic [7:0]  hub_req = 8'h00,
   // shared pins
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   output logic      [31:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // a core holds its request until done, then asks again while go
   always @(posedge clock or negedge rst_n)
      if (!rst_n)
         hub_req <= 8'h00;
      else
         hub_req <= (hub_req & ~hub_done) | (~hub_req & go);
   // driven pins echo, others take the outside level
   assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// [testbench/shh_hub_properties.sv]
`default_nettype none
module shh_hub_properties
(
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // hub, counter and pins
   input  wire logic [7:0]               hub_req,
   input  wire logic [7:0]               hub_exec,
   input  wire logic [7:0]               hub_done,
   input  wire logic [2:0]               hub_slot,
   input  wire logic [31:0]              system_counter_view,
   input  wire logic [31:0]              pin_out,
   input  wire logic [31:0]              pin_oe,
   input  wire shh_pkg::shh_ahb_rsp_type ahb_rsp
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // rotator
   // ------------------------------------------------------------
   // slot steps up every two cycles
   slot_step_a: assert property ($changed(hub_slot) |->
      hub_slot == $past(hub_slot) + 3'h1 ##1 $stable(hub_slot) ##1 $changed(hub_slot))
      else $error("slot step wrong");
   // one new grant per cycle at most
   start_one_a: assert property ($onehot0(hub_exec & ~$past(hub_exec)))
      else $error("two grants at once");
   // per core hub operation timing
   for (genvar c = 0; c < 8; c++)
   begin : g_core
      exec_len_a: assert property ($rose(hub_exec[c]) |->
         hub_exec[c][*7] ##1 (!hub_exec[c] && hub_done[c])) else $error("exec length wrong");
      take_req_a: assert property ($rose(hub_exec[c]) |-> $past(hub_req[c]))
         else $error("grant without request");
      done_pulse_a: assert property (hub_done[c] |=> !hub_done[c])
         else $error("done too long");
      exec_gap_a: assert property ($fell(hub_exec[c]) |=> (!$rose(hub_exec[c]))[*8])
         else $error("window too early");
   end
   // ------------------------------------------------------------
   // pins and counter
   // ------------------------------------------------------------
   // output masked by direction
   pin_mask_a: assert property ((pin_out & ~pin_oe) == 32'h0)
      else $error("undriven pin has output");
   cnt_step_a: assert property ($past(rst_n) |->
      system_counter_view == $past(system_counter_view) + 32'h1) else $error("count step");
   // main scenarios
   first_grant_c: cover property ($rose(hub_exec[0]));
   last_grant_c: cover property ($rose(hub_exec[7]));
   read_wait_c: cover property (!ahb_rsp.hreadyout);
endmodule
bind shh_hub shh_hub_properties shh_hub_properties_i
(
   .clock(clock), .rst_n(rst_n), .hub_req(hub_req), .hub_exec(hub_exec),
   .hub_done(hub_done), .hub_slot(hub_slot), .system_counter_view(system_counter_view),
   .pin_out(pin_out), .pin_oe(pin_oe), .ahb_rsp(ahb_rsp)
);
`default_nettype wire

// [testbench/tb_shh_hub.sv]
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_shh_hub;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clock = 1'b0;
   logic             rst_n = 1'b0;
   logic [70:0]      ar = '0;
   logic [7:0]       go = '0;
   logic [7:0]       ex_q = '0;
   logic [31:0]      ext_lvl = '0;
   logic [7:0][31:0] extra = '0;
   logic [31:0]      cyc = '0;
   logic [31:0]      q, q2, t;
   logic [31:0]      last [8];
   logic [31:0]      prev [8];
   logic [23:0]      tbl [9] = '{24'h000000, 24'h010000, 24'h010100, 24'h010200,
      24'h030200, 24'hFF0A00, 24'hFF0800, 24'hF70800, 24'h020002};
   int               err_total = 0;
   int               checks = 0;
   shh_pkg::shh_ahb_rsp_type rsp;
   wire shh_pkg::shh_ahb_req_type bus = {ar, rsp.hreadyout};
   wire logic [7:0]  req, exec, done;
   wire logic [31:0] cnt, p_in, p_out, p_oe;
   wire logic [2:0]  slot;
   wire logic [7:0]  en;
   shh_hub shh_hub_i (.clock(clock), .rst_n(rst_n), .ahb_req(bus), .ahb_rsp(rsp),
      .hub_req(req), .hub_exec(exec), .hub_done(done), .hub_slot(slot), .core_enable(en),
      .core_io_extra(extra), .system_counter_view(cnt), .pin_in(p_in),
      .pin_out(p_out), .pin_oe(p_oe));
   shh_core_model shh_core_model_i (.clock(clock), .rst_n(rst_n), .go(go),
      .ext_lvl(ext_lvl), .hub_done(done), .hub_req(req), .pin_out(p_out),
      .pin_oe(p_oe), .pin_in(p_in));
   // clock
   always #12.5 clock = ~clock;
   // cycle count, grant times and hang guard
   always @(posedge clock)
   begin
      cyc <= cyc + 32'h1;
      ex_q <= exec;
      for (int c = 0; c < 8; c++)
         if (exec[c] && !ex_q[c])
         begin
            prev[c] = last[c];
            last[c] = cyc;
            `CHK(slot, 3'(c))
         end
      if (cyc == 32'd5000)
      begin
         err_total++;
         results();
      end
   end
   // one single word transfer, read data lands in q
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      ar <= {1'b1, a, shh_pkg::HTRANS_NONSEQ, w, 3'h2, ar[31:0]};
      do @(posedge clock); while (rsp.hreadyout !== 1'b1);
      ar <= {1'b0, a, 2'h0, w, 3'h2, d};
      do @(posedge clock); while (rsp.hreadyout !== 1'b1);
      q = rsp.hrdata;
   endtask
   // byte address of a core's special register
   function automatic logic [31:0] sa(input int c, input int i);
      return 32'h7C0 + 32'(c) * 32'h800 + 32'(i) * 32'h4;
   endfunction
   // verdict
   task automatic results();
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      `CHK(cnt != 32'h0, 1'b1)
      `CHK(slot, 3'h0)
      xfer(0, sa(0, 1), 0);
      `CHK(cnt - q, 32'h1)
      q2 = q;
      t = cyc;
      xfer(0, sa(5, 1), 0);
      `CHK(q - q2, cyc - t)
      xfer(0, 32'h4010, 0);
      `CHK(q, 32'h0)
      `CHK(rsp.hresp, 1'b0)
      xfer(1, 32'h4000, 32'hFF);
      // sharing table on every pin
      for (int e = 0; e < 9; e++)
      begin
         for (int c = 0; c < 8; c++)
         begin
            xfer(1, sa(c, 6), {32{tbl[e][16 + c]}});
            xfer(1, sa(c, 4), {32{tbl[e][8 + c]}});
            extra[c] <= {32{tbl[e][c]}};
         end
         repeat (3) @(posedge clock);
         `CHK(p_oe, {32{|tbl[e][23:16]}})
         `CHK(p_out, {32{|(tbl[e][23:16] & (tbl[e][15:8] | tbl[e][7:0]))}})
      end
      xfer(1, 32'h4000, 32'hFD);
      repeat (3) @(posedge clock);
      `CHK({p_oe, p_out}, 64'h0)
      `CHK(en, 8'hFD)
      xfer(1, 32'h4000, 32'hFF);
      xfer(0, sa(1, 6), 0);
      `CHK(q, 32'h0)
      xfer(1, sa(0, 6), 32'h0000FFFF);
      xfer(1, sa(0, 4), 32'h000012A5);
      for (int k = 0; k < 2; k++)
      begin
         ext_lvl <= k ? 32'h3C3C0000 : 32'hC3C30000;
         repeat (6) @(posedge clock);
         xfer(0, sa(2 + 4 * k, 2), 0);
         `CHK(q, {k ? 16'h3C3C : 16'hC3C3, 16'h12A5})
      end
      go <= 8'hFF;
      repeat (48) @(posedge clock);
      go <= 8'h00;
      repeat (24) @(posedge clock);
      for (int c = 0; c < 8; c++)
      begin
         `CHK(last[c] - prev[c], 32'd16)
         `CHK((last[c] - last[0]) & 32'hF, 32'(2 * c))
      end
      go <= 8'h20;
      t = cyc;
      do @(posedge clock); while (done[5] !== 1'b1 && cyc - t < 32'd40);
      go <= 8'h00;
      `CHK(cyc - t <= 32'd26, 1'b1)
      results();
   end
endmodule
`default_nettype wire
